//--- design/caf_pkg.sv
// constants, register map and field layout of the acceptance filter block
// Operation
// - a compared standard id bit matches only when message bit equals filter bit
// - with type matching, extended-select 1 takes only extended, 0 only standard
// - compared extended id bits, including the upper two, match only on equality
// - two-bit mask source: 11 no mask, 10 mask 2, 01 mask 1, 00 mask 0
// - low select register holds filters 7..0, high register filters 15..8
// - standard mask bits 15-5: 1 compares the id bit, 0 makes it don't-care
// - mask bits 1-0 of the standard mask register cover extended id bits 17-16
// - mask type-mode bit 3 set forces id type to agree with extended-select
// - type-mode bit clear accepts either type when compared id bits match
// - three independent masks, each with standard and extended mask registers
// - bits 4 and 2 of the mask standard register read back as zero
// - extended mask register holds sixteen compare enables for id bits 15-0
// - only enabled filters may hit; a disabled filter never hits
package caf_pkg;

    localparam int NUM_FILTERS = 16;
    localparam int NUM_MASKS   = 3;
    localparam int PADDR_W     = 12;

    // byte offsets on the register bus, one aligned word each
    localparam logic [7:0] OFS_FLT_SID  = 8'h00;  // 16 words, filter n at +4n
    localparam logic [7:0] OFS_FLT_EID  = 8'h40;  // 16 words
    localparam logic [7:0] OFS_MSKSEL_L = 8'h80;
    localparam logic [7:0] OFS_MSKSEL_H = 8'h84;
    localparam logic [7:0] OFS_MSK_SID  = 8'h88;  // 3 words
    localparam logic [7:0] OFS_MSK_EID  = 8'h94;  // 3 words
    localparam logic [7:0] OFS_FLT_EN   = 8'ha0;
    localparam logic [7:0] OFS_HIT_STAT = 8'ha4;

    // values after reset
    localparam logic [15:0] RST_MSKSEL = 16'h0000;
    localparam logic [15:0] RST_FLT_EN = 16'hffff;
    localparam logic [15:0] RST_ID     = 16'h0000;

    // standard-id register layout, shared by filters and masks
    localparam int SID_MSB   = 15;
    localparam int SID_LSB   = 5;
    localparam int TYPE_BIT  = 3;   // extended-select in filters, type mode in masks
    localparam int EIDH_MSB  = 1;
    localparam logic [15:0] SID_REG_WMASK  = 16'hffeb;  // bits 4 and 2 unimplemented
    localparam logic [15:0] MASK_ALL_CARE  = 16'hffff;

    typedef enum logic [1:0] {
        SRC_MASK0 = 2'b00,
        SRC_MASK1 = 2'b01,
        SRC_MASK2 = 2'b10,
        SRC_NONE  = 2'b11
    } caf_mask_src_type;

endpackage : caf_pkg

//--- design/caf_if.sv
// interfaces joining the register file, bus port and filter matcher
`timescale 1ns/1ps
`default_nettype none

interface caf_match_if;
    import caf_pkg::*;
    logic [10:0]            msg_sid;
    logic [17:0]            msg_eid;
    logic                   msg_ide;
    logic [15:0]            flt_sid [NUM_FILTERS];
    logic [15:0]            flt_eid [NUM_FILTERS];
    logic [31:0]            msksel;
    logic [15:0]            msk_sid [NUM_MASKS];
    logic [15:0]            msk_eid [NUM_MASKS];
    logic [15:0]            flt_en;
    logic [NUM_FILTERS-1:0] hit;

    modport cfg (output msg_sid, msg_eid, msg_ide, flt_sid, flt_eid, msksel,
                 msk_sid, msk_eid, flt_en, input hit);
    modport mat (input msg_sid, msg_eid, msg_ide, flt_sid, flt_eid, msksel,
                 msk_sid, msk_eid, flt_en, output hit);
endinterface : caf_match_if

interface caf_reg_if;
    logic        wr_en;
    logic        rd_setup;
    logic [5:0]  idx;
    logic [15:0] wdata;
    logic [1:0]  wlane;

    modport port (output wr_en, rd_setup, idx, wdata, wlane);
    modport regs (input wr_en, rd_setup, idx, wdata, wlane);
endinterface : caf_reg_if

`default_nettype wire

//--- design/caf_filter_match.sv
// per-filter identifier compare against the selected acceptance mask
`timescale 1ns/1ps
`default_nettype none

module caf_filter_match
    import caf_pkg::*;
(
    caf_match_if.mat mif
);

    for (genvar f = 0; f < NUM_FILTERS; f++)
    begin : g_flt
        caf_mask_src_type src;
        logic [15:0]      m_sid;
        logic [15:0]      m_eid;
        logic [10:0]      sid_care;
        logic [17:0]      eid_care;
        logic [17:0]      flt_eid_full;
        logic             id_type_match_mode;
        logic             filter_ext_select;
        logic             sid_ok;
        logic             eid_ok;
        logic             match;

        assign src = caf_mask_src_type'(mif.msksel[2*f +: 2]);

        // mask source pick; no-mask forces every care bit and type mode
        always_comb
        begin
            unique case (src)
                SRC_MASK0:
                begin
                    m_sid = mif.msk_sid[0];
                    m_eid = mif.msk_eid[0];
                end
                SRC_MASK1:
                begin
                    m_sid = mif.msk_sid[1];
                    m_eid = mif.msk_eid[1];
                end
                SRC_MASK2:
                begin
                    m_sid = mif.msk_sid[2];
                    m_eid = mif.msk_eid[2];
                end
                SRC_NONE:
                begin
                    m_sid = MASK_ALL_CARE;
                    m_eid = MASK_ALL_CARE;
                end
            endcase
        end

        assign sid_care     = m_sid[SID_MSB:SID_LSB];
        assign eid_care     = {m_sid[EIDH_MSB:0], m_eid};
        assign id_type_match_mode         = m_sid[TYPE_BIT];
        assign filter_ext_select        = mif.flt_sid[f][TYPE_BIT];
        assign flt_eid_full = {mif.flt_sid[f][EIDH_MSB:0], mif.flt_eid[f]};

        // a don't-care bit always agrees
        assign sid_ok = &(~(mif.msg_sid ^ mif.flt_sid[f][SID_MSB:SID_LSB]) | ~sid_care);
        assign eid_ok = &(~(mif.msg_eid ^ flt_eid_full) | ~eid_care);

        // type mode: id type must follow the filter, else either type passes
        assign match = id_type_match_mode ? ((mif.msg_ide == filter_ext_select) && sid_ok && (!filter_ext_select || eid_ok))
                            : (sid_ok && (!mif.msg_ide || eid_ok));
        assign mif.hit[f] = mif.flt_en[f] & match;
    end

endmodule : caf_filter_match

`default_nettype wire

//--- design/caf_apb_port.sv
// apb slave front end: decode, zero-wait ready, error on unmapped words
`timescale 1ns/1ps
`default_nettype none

module caf_apb_port
    import caf_pkg::*;
(
    // clock and reset
    input  wire logic               core_clk,
    input  wire logic               reset_n,
    input  wire logic               ce,
    // apb
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [PADDR_W-1:0] paddr,
    input  wire logic [31:0]        pwdata,
    input  wire logic [3:0]         pstrb,
    output logic                    pready,
    output logic                    pslverr,
    // register file side
    caf_reg_if.port                 rif
);

    logic       mapped;
    logic       err_q;
    logic [5:0] last_idx;

    assign last_idx = OFS_HIT_STAT[7:2];
    assign mapped   = (paddr[PADDR_W-1:8] == '0) && (paddr[1:0] == 2'b00)
                      && (paddr[7:2] <= last_idx);

    // error decided in setup so the access cycle answers from a flop
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
            err_q <= 1'b0;
        else if (ce && psel && !penable)
            err_q <= ~mapped;
    end

    // frozen clock enable stretches the access phase instead of losing it
    assign pready       = psel & penable & ce;
    assign pslverr      = pready & err_q;
    assign rif.wr_en    = pready & pwrite & ~err_q;
    assign rif.rd_setup = ce & psel & ~penable & ~pwrite;
    // refused words point at an empty index so a high-page alias reads zero
    assign rif.idx      = mapped ? paddr[7:2] : 6'h3f;
    assign rif.wdata    = pwdata[15:0];
    assign rif.wlane    = pstrb[1:0];

endmodule : caf_apb_port

`default_nettype wire

//--- design/caf_top.sv
// acceptance filter and mask block: register file, bus port, hit reporting
//
// Our own choices: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none

module caf_top
    import caf_pkg::*;
#(
    parameter int N_FILTERS = NUM_FILTERS
)
(
    // clock, reset, enable
    input  wire logic               core_clk,
    input  wire logic               reset_n,
    input  wire logic               ce,
    // apb slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [PADDR_W-1:0] paddr,
    input  wire logic [31:0]        pwdata,
    input  wire logic [3:0]         pstrb,
    output logic                    pready,
    output logic [31:0]             prdata,
    output logic                    pslverr,
    // received identifier from the bus receiver
    input  wire logic               msg_valid,
    input  wire logic [10:0]        msg_sid,
    input  wire logic [17:0]        msg_eid,
    input  wire logic               msg_ide,
    // acceptance result
    output logic                    hit_valid,
    output logic [N_FILTERS-1:0]    hit_vector,
    output logic                    hit_found,
    output logic [3:0]              hit_index
);

    // selector layout is fixed at two registers of eight filters
    if (N_FILTERS != NUM_FILTERS)
    begin : g_bad_filters
        $error("caf_top: N_FILTERS must be 16");
    end

    caf_match_if mif ();
    caf_reg_if   rif ();

    // register state
    logic [15:0] flt_sid_q [NUM_FILTERS];
    logic [15:0] flt_eid_q [NUM_FILTERS];
    logic [31:0] msksel_q;
    logic [15:0] msk_sid_q [NUM_MASKS];
    logic [15:0] msk_eid_q [NUM_MASKS];
    logic [15:0] flt_en_q;
    logic [31:0] prdata_q;
    logic [31:0] rdata_d;

    // result state
    logic                   hit_valid_q;
    logic [NUM_FILTERS-1:0] hit_vector_q;
    logic                   hit_found_q;
    logic [3:0]             hit_index_q;
    logic                   found_d;
    logic [3:0]             index_d;

    // word indices of the register groups
    logic [5:0] i_flt_sid;
    logic [5:0] i_flt_eid;
    logic [5:0] i_msk_sid;
    logic [5:0] i_msk_eid;

    assign i_flt_sid = OFS_FLT_SID[7:2];
    assign i_flt_eid = OFS_FLT_EID[7:2];
    assign i_msk_sid = OFS_MSK_SID[7:2];
    assign i_msk_eid = OFS_MSK_EID[7:2];

    // byte-lane merge, then clear bits the register does not implement
    function automatic logic [15:0] caf_merge(
        input logic [15:0] old_v,
        input logic [15:0] new_v,
        input logic [1:0]  lane,
        input logic [15:0] keep
    );
        logic [15:0] lm;
        lm = {{8{lane[1]}}, {8{lane[0]}}};
        return ((old_v & ~lm) | (new_v & lm)) & keep;
    endfunction : caf_merge

    caf_apb_port u_port (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .ce       (ce),
        .psel     (psel),
        .penable  (penable),
        .pwrite   (pwrite),
        .paddr    (paddr),
        .pwdata   (pwdata),
        .pstrb    (pstrb),
        .pready   (pready),
        .pslverr  (pslverr),
        .rif      (rif.port)
    );

    // filter identifier registers; cleared at reset so no unknown hits leak
    for (genvar f = 0; f < NUM_FILTERS; f++)
    begin : g_flt_regs
        always_ff @(posedge core_clk)
        begin
            if (!reset_n)
            begin
                flt_sid_q[f] <= RST_ID;
                flt_eid_q[f] <= RST_ID;
            end
            else if (ce && rif.wr_en)
            begin
                if (rif.idx == i_flt_sid + 6'(f))
                    flt_sid_q[f] <= caf_merge(flt_sid_q[f], rif.wdata, rif.wlane,
                                              SID_REG_WMASK);
                if (rif.idx == i_flt_eid + 6'(f))
                    flt_eid_q[f] <= caf_merge(flt_eid_q[f], rif.wdata, rif.wlane,
                                              MASK_ALL_CARE);
            end
        end
    end

    // three independent masks
    for (genvar m = 0; m < NUM_MASKS; m++)
    begin : g_msk_regs
        always_ff @(posedge core_clk)
        begin
            if (!reset_n)
            begin
                msk_sid_q[m] <= RST_ID;
                msk_eid_q[m] <= RST_ID;
            end
            else if (ce && rif.wr_en)
            begin
                if (rif.idx == i_msk_sid + 6'(m))
                    msk_sid_q[m] <= caf_merge(msk_sid_q[m], rif.wdata, rif.wlane,
                                              SID_REG_WMASK);
                if (rif.idx == i_msk_eid + 6'(m))
                    msk_eid_q[m] <= caf_merge(msk_eid_q[m], rif.wdata, rif.wlane,
                                              MASK_ALL_CARE);
            end
        end
    end

    // mask source selectors, low half filters 7..0, high half 15..8
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
            msksel_q <= {RST_MSKSEL, RST_MSKSEL};
        else if (ce && rif.wr_en)
        begin
            if (rif.idx == OFS_MSKSEL_L[7:2])
                msksel_q[15:0] <= caf_merge(msksel_q[15:0], rif.wdata, rif.wlane,
                                            MASK_ALL_CARE);
            if (rif.idx == OFS_MSKSEL_H[7:2])
                msksel_q[31:16] <= caf_merge(msksel_q[31:16], rif.wdata, rif.wlane,
                                             MASK_ALL_CARE);
        end
    end

    // per-filter enables, all on after reset
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
            flt_en_q <= RST_FLT_EN;
        else if (ce && rif.wr_en && rif.idx == OFS_FLT_EN[7:2])
            flt_en_q <= caf_merge(flt_en_q, rif.wdata, rif.wlane, MASK_ALL_CARE);
    end

    // matcher sees live configuration and the presented identifier
    assign mif.msg_sid = msg_sid;
    assign mif.msg_eid = msg_eid;
    assign mif.msg_ide = msg_ide;
    assign mif.msksel  = msksel_q;
    assign mif.flt_en  = flt_en_q;
    for (genvar f = 0; f < NUM_FILTERS; f++)
    begin : g_cfg_f
        assign mif.flt_sid[f] = flt_sid_q[f];
        assign mif.flt_eid[f] = flt_eid_q[f];
    end
    for (genvar m = 0; m < NUM_MASKS; m++)
    begin : g_cfg_m
        assign mif.msk_sid[m] = msk_sid_q[m];
        assign mif.msk_eid[m] = msk_eid_q[m];
    end

    caf_filter_match u_match (
        .mif (mif.mat)
    );

    // lowest-numbered hitting filter wins the reported index
    always_comb
    begin
        found_d = 1'b0;
        index_d = 4'h0;
        for (int i = NUM_FILTERS - 1; i >= 0; i--)
        begin
            if (mif.hit[i])
            begin
                found_d = 1'b1;
                index_d = 4'(i);
            end
        end
    end

    // one-cycle result pulse; vector and index hold until the next message
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            hit_valid_q  <= 1'b0;
            hit_vector_q <= '0;
            hit_found_q  <= 1'b0;
            hit_index_q  <= 4'h0;
        end
        else if (ce)
        begin
            hit_valid_q <= msg_valid;
            if (msg_valid)
            begin
                hit_vector_q <= mif.hit;
                hit_found_q  <= found_d;
                hit_index_q  <= index_d;
            end
        end
    end

    // read mux; unmapped words return zero and the port flags the error
    always_comb
    begin
        rdata_d = 32'h0000_0000;
        if (rif.idx < i_flt_eid)
            rdata_d[15:0] = flt_sid_q[rif.idx[3:0]];
        else if (rif.idx < OFS_MSKSEL_L[7:2])
            rdata_d[15:0] = flt_eid_q[rif.idx[3:0]];
        else if (rif.idx == OFS_MSKSEL_L[7:2])
            rdata_d[15:0] = msksel_q[15:0];
        else if (rif.idx == OFS_MSKSEL_H[7:2])
            rdata_d[15:0] = msksel_q[31:16];
        else if (rif.idx == i_msk_sid)
            rdata_d[15:0] = msk_sid_q[0];
        else if (rif.idx == i_msk_sid + 6'h01)
            rdata_d[15:0] = msk_sid_q[1];
        else if (rif.idx == i_msk_sid + 6'h02)
            rdata_d[15:0] = msk_sid_q[2];
        else if (rif.idx == i_msk_eid)
            rdata_d[15:0] = msk_eid_q[0];
        else if (rif.idx == i_msk_eid + 6'h01)
            rdata_d[15:0] = msk_eid_q[1];
        else if (rif.idx == i_msk_eid + 6'h02)
            rdata_d[15:0] = msk_eid_q[2];
        else if (rif.idx == OFS_FLT_EN[7:2])
            rdata_d[15:0] = flt_en_q;
        else if (rif.idx == OFS_HIT_STAT[7:2])
            rdata_d[20:0] = {hit_found_q, hit_index_q, hit_vector_q};
    end

    // read data captured in setup so it stands from a flop in the access cycle
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
            prdata_q <= 32'h0000_0000;
        else if (rif.rd_setup)
            prdata_q <= rdata_d;
    end

    assign prdata     = prdata_q;
    assign hit_valid  = hit_valid_q;
    assign hit_vector = hit_vector_q;
    assign hit_found  = hit_found_q;
    assign hit_index  = hit_index_q;

endmodule : caf_top

`default_nettype wire

//--- testbench/caf_props.sv
// checker for the bus port and hit reporting of the acceptance filter block
`timescale 1ns/1ps
`default_nettype none

module caf_props
    import caf_pkg::*;
#(
    parameter int N_FILTERS = NUM_FILTERS
)
(
    // clock, reset, enable
    input wire logic                 core_clk,
    input wire logic                 reset_n,
    input wire logic                 ce,
    // apb
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pwrite,
    input wire logic [PADDR_W-1:0]   paddr,
    input wire logic                 pready,
    input wire logic [31:0]          prdata,
    input wire logic                 pslverr,
    // message and result
    input wire logic                 msg_valid,
    input wire logic                 hit_valid,
    input wire logic [N_FILTERS-1:0] hit_vector,
    input wire logic                 hit_found,
    input wire logic [3:0]           hit_index
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    // access phase and address decode seen from the pins
    wire logic acc;
    wire logic bad;
    wire logic sid_reg;
    assign acc = psel && penable && ce;
    assign bad = (paddr[11:8] != 4'h0) || (paddr[1:0] != 2'b00) || (paddr[7:0] > 8'ha4);
    assign sid_reg = (paddr[7:0] < 8'h40) || (paddr[7:0] >= 8'h88 && paddr[7:0] < 8'h94);

    // a message is taken, then the result lands one edge later
    sequence s_taken;
        msg_valid && ce;
    endsequence
    sequence s_answer;
        hit_valid && (hit_found == (|hit_vector));
    endsequence

    a_ready_zero_wait: assert property (pready == acc)
        else $error("pready does not follow the access phase");
    a_err_unmapped: assert property (acc && bad |-> pslverr)
        else $error("unmapped access without error");
    a_err_mapped: assert property (acc && !bad |-> !pslverr)
        else $error("mapped access flagged as error");
    a_rd_bad_zero: assert property (acc && !pwrite && bad |-> prdata == 32'h0)
        else $error("unmapped read returns data");
    a_sid_unimpl: assert property (acc && !pwrite && !bad && sid_reg |-> !prdata[4] && !prdata[2])
        else $error("unimplemented id bits read as one");
    a_hit_answer: assert property (s_taken |=> s_answer)
        else $error("no result one cycle after a message");
    a_hit_quiet: assert property (!(msg_valid && ce) |=>
        $stable(hit_vector) && (!hit_valid || !$past(ce)))
        else $error("result moved without a message");
    a_index_lowest: assert property (hit_valid && hit_found |->
        hit_vector[hit_index] && ((hit_vector & ~({N_FILTERS{1'b1}} << hit_index)) == '0))
        else $error("hit index is not the lowest hit");
    a_none_zero: assert property (hit_valid && !hit_found |-> hit_index == 4'h0 && hit_vector == '0)
        else $error("empty result not all zero");
endmodule : caf_props

`default_nettype wire

//--- testbench/caf_node_model.sv
// remote node model that presents received identifiers to the filter block
`timescale 1ns/1ps
`default_nettype none

module caf_node_model
(
    // clock
    input  wire logic       core_clk,
    // received identifier
    output var logic        msg_valid,
    output var logic [10:0] msg_sid,
    output var logic [17:0] msg_eid,
    output var logic        msg_ide
);
    // lines start quiet
    initial
    begin
        msg_valid = 1'b0;
        msg_sid = 11'h0;
        msg_eid = 18'h0;
        msg_ide = 1'b0;
    end

    // one identifier per edge, back to back allowed
    task automatic send(input logic [10:0] sid, input logic [17:0] eid, input logic ide);
        @(posedge core_clk);
        msg_valid <= 1'b1;
        msg_sid <= sid;
        msg_eid <= eid;
        msg_ide <= ide;
    endtask : send

    // stale lines flip so an old identifier cannot pass for a new one
    task automatic idle();
        @(posedge core_clk);
        msg_valid <= 1'b0;
        msg_sid <= ~msg_sid;
        msg_eid <= ~msg_eid;
        msg_ide <= ~msg_ide;
    endtask : idle
endmodule : caf_node_model

`default_nettype wire

//--- testbench/can_acceptance_filter_mask_test.sv
// self-checking bench for the acceptance filter and mask block
`timescale 1ns/1ps
`default_nettype none

module can_acceptance_filter_mask_test;
    import caf_pkg::*;

    logic        core_clk;
    logic        reset_n;
    logic        ce;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        msg_valid;
    logic [10:0] msg_sid;
    logic [17:0] msg_eid;
    logic        msg_ide;
    logic        hit_valid;
    logic [15:0] hit_vector;
    logic        hit_found;
    logic [3:0]  hit_index;
    logic [15:0] sh [42];
    logic [32:0] rdq [$];
    logic [20:0] hq [$];
    logic [20:0] last_hit;
    logic [10:0] sid;
    logic [17:0] eid;
    logic        ide;
    logic        c;
    int          k;
    int          seed = 40018;
    int          mismatches = 0;
    int          check_count = 0;
    int          cycles = 0;

    caf_top DUT (.core_clk, .reset_n, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .pready, .prdata, .pslverr, .msg_valid, .msg_sid, .msg_eid, .msg_ide, .hit_valid,
        .hit_vector, .hit_found, .hit_index);
    caf_node_model u_node (.core_clk, .msg_valid, .msg_sid, .msg_eid, .msg_ide);

    // 200 MHz clock
    initial
    begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    task automatic chk(input string what, input logic [32:0] exp, input logic [32:0] got);
        check_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : conclude

    // reference acceptance: filter id, selected mask, type mode, enable
    function automatic logic [20:0] model(input logic [10:0] s, input logic [17:0] e,
                                          input logic t);
        logic [15:0] v;
        logic [15:0] ms;
        logic [15:0] me;
        logic [1:0]  sel;
        logic [3:0]  idx;
        logic        so;
        logic        eo;
        v = 16'h0;
        idx = 4'h0;
        for (int f = 0; f < 16; f++)
        begin
            sel = sh[32 + f / 8][(f % 8) * 2 +: 2];
            ms = (sel == 2'b11) ? MASK_ALL_CARE : sh[34 + sel];
            me = (sel == 2'b11) ? MASK_ALL_CARE : sh[37 + sel];
            so = ((s ^ sh[f][15:5]) & ms[15:5]) == 11'h0;
            eo = ((e ^ {sh[f][1:0], sh[16 + f]}) & {ms[1:0], me}) == 18'h0;
            v[f] = ms[3] ? (t == sh[f][3]) && so && (!sh[f][3] || eo) : so && (!t || eo);
            v[f] = v[f] && sh[40][f];
        end
        for (int f = 15; f >= 0; f--)
            if (v[f])
                idx = 4'(f);
        return {|v, idx, v};
    endfunction : model

    // apb transfer on word i; the shadow and the read note are kept here
    task automatic apb(input logic w, input int i, input logic [15:0] d, input logic [1:0] s);
        logic [15:0] lm;
        lm = {{8{s[1]}}, {8{s[0]}}};
        if (w && i < 41)
            sh[i] = ((sh[i] & ~lm) | (d & lm))
                  & ((i < 16 || (i > 33 && i < 37)) ? SID_REG_WMASK : 16'hffff);
        if (!w)
            rdq.push_back(i > 41 ? {1'b1, 32'h0} : i == 41 ? {12'h0, last_hit} : {17'h0, sh[i]});
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= 12'(i * 4);
        pwdata <= {16'($random(seed)), d};
        pstrb <= {2'($random(seed)), s};
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // result watcher: oldest note against what the block shows
    always @(posedge core_clk)
    begin
        if (psel && penable && pready === 1'b1 && !pwrite)
            chk("read", rdq.pop_front(), {pslverr, prdata});
        if (hit_valid === 1'b1 && ce)
            chk("hit", {12'h0, hq.pop_front()}, {12'h0, hit_found, hit_index, hit_vector});
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            conclude();
        end
    end

    initial
    begin
        reset_n = 1'b0;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        pstrb = 4'h0;
        last_hit = 21'h0;
        for (int i = 0; i < 42; i++)
            sh[i] = RST_ID;
        sh[32] = RST_MSKSEL;
        sh[33] = RST_MSKSEL;
        sh[40] = RST_FLT_EN;
        repeat (10) @(posedge core_clk);
        reset_n <= 1'b1;
        // reset values, unmapped words, lane writes
        for (int i = 0; i < 42; i++)
            apb(1'b0, i, 16'h0, 2'b11);
        apb(1'b1, 64, 16'hffff, 2'b11);
        apb(1'b0, 64, 16'h0, 2'b11);
        apb(1'b0, 42, 16'h0, 2'b11);
        apb(1'b1, 34, 16'hffff, 2'b01);
        apb(1'b0, 34, 16'h0, 2'b11);
        // rounds: every selector code on all filters, then random codes and stalls
        for (int r = 0; r < 6; r++)
        begin
            for (int i = 0; i < 32; i++)
                apb(1'b1, i, 16'($random(seed)), 2'b11);
            for (int i = 34; i < 40; i++)
                apb(1'b1, i, 16'($random(seed)) & 16'($random(seed)), 2'b11);
            apb(1'b1, 32, r < 4 ? {8{2'(r)}} : 16'($random(seed)), 2'b11);
            apb(1'b1, 33, r < 4 ? {8{2'(r)}} : 16'($random(seed)), 2'b11);
            apb(1'b1, 40, 16'($random(seed)) | 16'($random(seed)), 2'b11);
            for (int i = 32; i < 41; i++)
                apb(1'b0, i, 16'h0, 2'b11);
            apb(1'b0, 64, 16'h0, 2'b11);
            for (int m = 0; m < 48; m++)
            begin
                k = $random(seed) & 15;
                sid = sh[k][15:5] ^ (11'($random(seed)) & 11'($random(seed)) & 11'($random(seed)));
                eid = {sh[k][1:0], sh[16 + k]} ^ (18'($random(seed)) & 18'($random(seed)));
                ide = (($random(seed) & 3) != 0) ? sh[k][3] : !sh[k][3];
                c = r < 4 || (($random(seed) & 3) != 0);
                if (c)
                begin
                    last_hit = model(sid, eid, ide);
                    hq.push_back(last_hit);
                end
                u_node.send(sid, eid, ide);
                ce <= c;
                if (($random(seed) & 3) == 0)
                    u_node.idle();
            end
            u_node.idle();
            ce <= 1'b1;
            apb(1'b0, 41, 16'h0, 2'b11);
        end
        repeat (4) @(posedge core_clk);
        if (hq.size() != 0 || rdq.size() != 0)
            mismatches++;
        conclude();
    end
endmodule : can_acceptance_filter_mask_test

bind caf_top caf_props #(.N_FILTERS(N_FILTERS)) u_props (.core_clk, .reset_n, .ce, .psel,
    .penable, .pwrite, .paddr, .pready, .prdata, .pslverr, .msg_valid, .hit_valid, .hit_vector,
    .hit_found, .hit_index);

`default_nettype wire
